// ### hw/p8pf_pkg.sv
// Constants, types and helpers shared by the port pin-function block
package p8pf_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [19:0] IDX_DIR       = 20'hEE007;
	localparam logic [19:0] IDX_DATA      = 20'hFFFD7;
	// Printed offsets are not word aligned, so they are indices of words
	localparam logic [31:0] ADDR_DIR      = {10'h000, IDX_DIR, 2'b00};
	localparam logic [31:0] ADDR_DATA     = {10'h000, IDX_DATA, 2'b00};
	localparam logic [31:0] ADDR_DRAM_CTL = 32'h0000_0100;
	localparam logic [31:0] ADDR_IRQ_EN   = 32'h0000_0104;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int          PORT_W        = 5;
	localparam int          IRQ_W         = 4;
	localparam logic [2:0]  RSVD_ONES     = 3'h7;
	localparam logic [7:0]  DIR_RST_NOROM = 8'hF0;
	localparam logic [7:0]  DIR_RST_OTHER = 8'hE0;
	localparam logic [7:0]  DATA_RST      = 8'hE0;
	localparam logic [7:0]  DIR_READ      = 8'hFF;
	localparam int          DCTL_AREA_LSB = 0;
	localparam int          DCTL_REFRESH_STROBE_OUT_BIT = 3;
	localparam logic [3:0]  DCTL_RST      = 4'h0;
	localparam logic [3:0]  IRQ_EN_RST    = 4'h0;

	// Area-select codes (one bit per code) giving each pin 2/1 option
	localparam logic [7:0]  PIN2_ROW_CODES = 8'hFE;
	localparam logic [7:0]  PIN1_PORT_CODES = 8'h0A;
	localparam logic [7:0]  PIN1_ROW_CODES = 8'hF4;

	// ----------------------------------------------------------------
	// Operating modes
	// ----------------------------------------------------------------
	localparam logic [2:0]  MODE_EXP_FIRST = 3'h1;
	localparam logic [2:0]  MODE_NOROM_LAST = 3'h4;
	localparam logic [2:0]  MODE_EXP_LAST = 3'h5;

	typedef enum logic [2:0] {
		REG_NONE,
		REG_DIR,
		REG_DATA,
		REG_DRAM_CTL,
		REG_IRQ_EN
	} p8pf_reg_t;

	typedef enum logic {
		BUS_IDLE,
		BUS_ACCESS
	} p8pf_bus_state_t;

	function automatic logic p8pfIsNoRom(input logic [2:0] mode);
		return (mode >= MODE_EXP_FIRST) && (mode <= MODE_NOROM_LAST);
	endfunction

	function automatic logic p8pfIsExpanded(input logic [2:0] mode);
		return (mode >= MODE_EXP_FIRST) && (mode <= MODE_EXP_LAST);
	endfunction

endpackage

// ### hw/p8pf_reg_if.sv
// Register access carrier between the bus slave and the register file
`timescale 1ns/1ps
interface p8pf_reg_if;
	import p8pf_pkg::*;

	logic       wrEn;
	p8pf_reg_t  sel;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport bus (
		output wrEn,
		output sel,
		output wdata,
		input  rdata
	);

	modport regs (
		input  wrEn,
		input  sel,
		input  wdata,
		output rdata
	);
endinterface

// ### hw/p8pf_mode_latch.sv
// Operating-mode strap capture
`timescale 1ns/1ps
module p8pf_mode_latch
	import p8pf_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       hwStandby,
	input  wire logic [2:0] modeStrap,
	output logic            expanded_q
);
	// ----------------------------------------------------------------
	// Strap is sampled through reset and hardware standby, then held until the next of either
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst || hwStandby) begin
			expanded_q <= p8pfIsExpanded(modeStrap);
		end
	end
endmodule

// ### hw/p8pf_ahb_slave.sv
// AHB-Lite slave front end, one wait state per whole-word transfer
`timescale 1ns/1ps
module p8pf_ahb_slave
	import p8pf_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata_q,
	output logic             hreadyout_q,
	output logic             hresp_q,
	p8pf_reg_if.bus          regPort
);
	import p8pf_pkg::*;

	p8pf_bus_state_t state_q;
	p8pf_reg_t       sel_q;
	logic            write_q;
	logic            accept;

	// Only whole-word transfers are decoded; others complete harmlessly
	assign accept = hsel && htrans[1] && hready && (hsize == 3'h2);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q     <= BUS_IDLE;
			sel_q       <= REG_NONE;
			write_q     <= 1'b0;
			hreadyout_q <= 1'b1;
			hrdata_q    <= 32'h0000_0000;
		end else if (state_q == BUS_IDLE) begin
			if (accept) begin
				state_q     <= BUS_ACCESS;
				write_q     <= hwrite;
				hreadyout_q <= 1'b0;
				unique case (haddr)
					ADDR_DIR:      sel_q <= REG_DIR;
					ADDR_DATA:     sel_q <= REG_DATA;
					ADDR_DRAM_CTL: sel_q <= REG_DRAM_CTL;
					ADDR_IRQ_EN:   sel_q <= REG_IRQ_EN;
					default:       sel_q <= REG_NONE;
				endcase
			end
		end else begin
			// Read data sampled after any earlier write has landed
			state_q     <= BUS_IDLE;
			hreadyout_q <= 1'b1;
			hrdata_q    <= {24'h00_0000, regPort.rdata};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hresp_q <= 1'b0;
		end else begin
			hresp_q <= 1'b0;
		end
	end

	assign regPort.wrEn  = (state_q == BUS_ACCESS) && write_q;
	assign regPort.sel   = sel_q;
	assign regPort.wdata = hwdata[7:0];
endmodule

// ### hw/p8pf_top.sv
// Five-pin general-purpose port with chip-select, row-strobe and refresh sharing
//
// Behaviour
// - Expanded modes 1-5: direction set on pins 4..1 drives selects 0..3.
// - Expanded modes: direction clear makes pin input unless DRAM/refresh overrides.
// - Pin 1 becomes plain output when direction set and area code selects it.
// - Pins 2,1 chosen by area code and direction; row strobes ignore direction.
// - DRAM in areas 2-5 turns selects 2,3 into row strobe outputs.
// - Modes 1-4 after reset: pin 4 drives select 0, others input.
// - Mode 5 after reset: all four select pins are inputs.
// - Refresh enable set: pin 0 drives refresh strobe regardless of direction.
// - Refresh enable clear: pin 0 follows its direction bit as port.
// - Single-chip modes 6,7: every pin is plain port per direction bit.
// - Direction register is write-only; reads return all ones.
// - Reset or hardware standby loads direction F0 (modes 1-4), E0 otherwise.
// - Software standby keeps direction, so outputs keep driving.
// - Pin used as output port drives its data register bit.
// - Data read gives stored bit when output, live pin level when input.
// - Bits 7-5 of both port registers read one and never change.
// - Data register resets to E0; software standby keeps it.
// - Interrupt inputs on pins 3-0 gated only by interrupt enables.
// - Pin 3 always feeds the external converter trigger.
`timescale 1ns/1ps
module p8pf_top
	import p8pf_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire logic                 hwStandby,
	input  wire logic [2:0]           modeStrap,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic                 hready,
	input  wire logic [31:0]          hwdata,
	output logic [31:0]               hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic [3:0]           chipSelectN,
	input  wire logic [1:0]           rowStrobeN,
	input  wire logic                 refreshStrobeN,
	input  wire logic [PORT_W-1:0]    pinIn,
	output logic [PORT_W-1:0]         pinOut,
	output logic [PORT_W-1:0]         pinOe,
	output logic [IRQ_W-1:0]          irqRequest,
	output logic                      adcTriggerN
);
	import p8pf_pkg::*;

	// ----------------------------------------------------------------
	// Shared signals
	// ----------------------------------------------------------------
	p8pf_reg_if            regBus ();
	logic                  expanded;
	logic [PORT_W-1:0]     dir_q;
	logic [PORT_W-1:0]     data_q;
	logic [3:0]            dramCtl_q;
	logic [IRQ_W-1:0]      irqEn_q;
	logic [2:0]            areaCode;
	logic                  refreshEn;
	logic                  pin2Row;
	logic                  pin1Port;
	logic                  pin1Row;
	logic [PORT_W-1:0]     pinOut_d;
	logic [PORT_W-1:0]     pinOe_d;
	logic [PORT_W-1:0]     pinOut_q;
	logic [PORT_W-1:0]     pinOe_q;
	logic [IRQ_W-1:0]      irqRequest_q;
	logic                  adcTriggerN_q;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	p8pf_ahb_slave uSlave (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.hsel        (hsel),
		.haddr       (haddr),
		.htrans      (htrans),
		.hwrite      (hwrite),
		.hsize       (hsize),
		.hready      (hready),
		.hwdata      (hwdata),
		.hrdata_q    (hrdata),
		.hreadyout_q (hreadyout),
		.hresp_q     (hresp),
		.regPort     (regBus.bus)
	);

	p8pf_mode_latch uMode (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.hwStandby  (hwStandby),
		.modeStrap  (modeStrap),
		.expanded_q (expanded)
	);

	// ----------------------------------------------------------------
	// Port registers
	// ----------------------------------------------------------------
	// Software standby needs no term: nothing here changes without a write
	always_ff @(posedge clk_sys) begin
		if (rst || hwStandby) begin
			if (p8pfIsNoRom(modeStrap)) begin
				dir_q <= DIR_RST_NOROM[PORT_W-1:0];
			end else begin
				dir_q <= DIR_RST_OTHER[PORT_W-1:0];
			end
		end else if (regBus.wrEn && (regBus.sel == REG_DIR)) begin
			dir_q <= regBus.wdata[PORT_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || hwStandby) begin
			data_q <= DATA_RST[PORT_W-1:0];
		end else if (regBus.wrEn && (regBus.sel == REG_DATA)) begin
			data_q <= regBus.wdata[PORT_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || hwStandby) begin
			dramCtl_q <= DCTL_RST;
		end else if (regBus.wrEn && (regBus.sel == REG_DRAM_CTL)) begin
			dramCtl_q <= regBus.wdata[3:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || hwStandby) begin
			irqEn_q <= IRQ_EN_RST;
		end else if (regBus.wrEn && (regBus.sel == REG_IRQ_EN)) begin
			irqEn_q <= regBus.wdata[IRQ_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		unique case (regBus.sel)
			REG_DIR: begin
				regBus.rdata = DIR_READ;
			end
			REG_DATA: begin
				// Inputs show the pin, outputs the stored bit
				regBus.rdata = {RSVD_ONES, (dir_q & data_q) | (~dir_q & pinIn)};
			end
			REG_DRAM_CTL: begin
				regBus.rdata = {4'h0, dramCtl_q};
			end
			REG_IRQ_EN: begin
				regBus.rdata = {4'h0, irqEn_q};
			end
			default: begin
				regBus.rdata = 8'h00;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Pin function selection
	// ----------------------------------------------------------------
	assign areaCode  = dramCtl_q[DCTL_AREA_LSB +: 3];
	assign refreshEn = dramCtl_q[DCTL_REFRESH_STROBE_OUT_BIT];
	assign pin2Row   = PIN2_ROW_CODES[areaCode];
	assign pin1Port  = PIN1_PORT_CODES[areaCode];
	assign pin1Row   = PIN1_ROW_CODES[areaCode];

	always_comb begin
		// Plain port by default: direction bit picks drive, data bit the level
		pinOe_d  = dir_q;
		pinOut_d = data_q;
		if (expanded) begin
			pinOut_d[4] = dir_q[4] ? chipSelectN[0] : data_q[4];
			pinOut_d[3] = dir_q[3] ? chipSelectN[1] : data_q[3];
			if (pin2Row) begin
				pinOe_d[2]  = 1'b1;
				pinOut_d[2] = rowStrobeN[0];
			end else begin
				pinOut_d[2] = dir_q[2] ? chipSelectN[2] : data_q[2];
			end
			if (pin1Row) begin
				pinOe_d[1]  = 1'b1;
				pinOut_d[1] = rowStrobeN[1];
			end else if (pin1Port) begin
				pinOut_d[1] = data_q[1];
			end else begin
				pinOut_d[1] = dir_q[1] ? chipSelectN[3] : data_q[1];
			end
			if (refreshEn) begin
				pinOe_d[0]  = 1'b1;
				pinOut_d[0] = refreshStrobeN;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registered pin and side outputs
	// ----------------------------------------------------------------
	// One cycle of latency buys glitch-free pad drive
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pinOe_q  <= {PORT_W{1'b0}};
			pinOut_q <= {PORT_W{1'b1}};
		end else begin
			pinOe_q  <= pinOe_d;
			pinOut_q <= pinOut_d;
		end
	end

	// Interrupt lines ignore direction: a driven pin can raise its own request
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irqRequest_q <= {IRQ_W{1'b0}};
		end else begin
			irqRequest_q <= irqEn_q & ~pinIn[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			adcTriggerN_q <= 1'b1;
		end else begin
			adcTriggerN_q <= pinIn[3];
		end
	end

	assign pinOe       = pinOe_q;
	assign pinOut      = pinOut_q;
	assign irqRequest  = irqRequest_q;
	assign adcTriggerN = adcTriggerN_q;
endmodule

// ### sim/p8pf_pin_partner.sv
// Pin-side partner: external devices sharing the port pins
`timescale 1ns/1ps
module p8pf_pin_partner (
	input  wire logic       clk_sys,
	input  wire logic [4:0] pinOut,
	input  wire logic [4:0] pinOe,
	input  wire logic [4:0] extOe,
	input  wire logic [4:0] extVal,
	output logic [4:0]      pinIn
);
	// Undriven lines have no pull: show a toggling pattern, never a held value
	logic [4:0] float_q = 5'h15;

	always_ff @(posedge clk_sys) begin
		float_q <= ~float_q;
	end

	always_comb begin
		for (int k = 0; k < 5; k++) begin
			pinIn[k] = pinOe[k] ? pinOut[k] : (extOe[k] ? extVal[k] : float_q[k]);
		end
	end
endmodule

// ### sim/p8pf_assertions.sv
// Port-level assertions for the port pin-function block
`timescale 1ns/1ps
module p8pf_assertions
	import p8pf_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [2:0]  modeStrap,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [3:0]  chipSelectN,
	input wire logic [4:0]  pinIn,
	input wire logic [4:0]  pinOut,
	input wire logic [4:0]  pinOe,
	input wire logic [3:0]  irqRequest,
	input wire logic        adcTriggerN
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic take;
	logic expMode;
	assign take = hsel && htrans[1] && hready && hsize == 3'h2;
	assign expMode = modeStrap >= 3'h1 && modeStrap <= 3'h5;
	sequence sRd(logic [31:0] a);
		take && !hwrite && haddr == a;
	endsequence
	AST_RESP: assert property (hresp == 1'b0) else $error("response not OKAY");
	AST_WAIT: assert property (take |=> !hreadyout ##1 hreadyout) else $error("wait state wrong");
	AST_DIR_RD: assert property (sRd(ADDR_DIR) |-> ##2 hrdata == 32'h0000_00FF)
		else $error("direction read not all ones");
	AST_DATA_RSV: assert property (sRd(ADDR_DATA) |-> ##2 hrdata[31:5] == 27'h7)
		else $error("reserved data bits wrong");
	AST_RST_PINS: assert property ($fell(rst) |=>
		pinOe == ((modeStrap >= 3'h1 && modeStrap <= 3'h4) ? 5'h10 : 5'h00))
		else $error("pin enables wrong after reset");
	AST_CS0: assert property (expMode && pinOe[4] |-> pinOut[4] == $past(chipSelectN[0]))
		else $error("select 0 not on pin 4");
	AST_IRQ: assert property ((irqRequest & $past(pinIn[3:0])) == 4'h0)
		else $error("interrupt without low pin");
	AST_ADC: assert property (!$past(rst) |-> adcTriggerN == $past(pinIn[3]))
		else $error("trigger does not follow pin 3");
endmodule
bind p8pf_top p8pf_assertions chk_u (.*);

// ### sim/tb.sv
// Self-checking bench for the port pin-function block
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
	import p8pf_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        hwStandby = 1'b0;
	logic [2:0]  modeStrap = 3'h1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic        hready;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [3:0]  chipSelectN = 4'hF;
	logic [1:0]  rowStrobeN = 2'h3;
	logic        refreshStrobeN = 1'b1;
	logic [4:0]  pinIn, pinOut, pinOe;
	logic [4:0]  extOe = 5'h1F;
	logic [4:0]  extVal = 5'h0;
	logic [3:0]  irqRequest;
	logic        adcTriggerN;
	logic [7:0]  dirM, dataM, ctlM, enM;
	logic [4:0]  oeE, outE, lvl;
	logic [31:0] rd;
	int          failures = 0;
	int          cmp_count = 0;
	int          seed = 32'h659ced85;

	assign hready = hreadyout;
	p8pf_top dut_u (.*);
	p8pf_pin_partner partner_u (.*);

	initial begin
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic finish_test();
		$display("failures %0d comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic waitRdy();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			failures++;
			finish_test();
		end
	endtask

	// ----------------------------------------------------------------
	// Single word transfer, entered just after a rising edge
	// ----------------------------------------------------------------
	task automatic ahb(input logic w, input logic [31:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		waitRdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		waitRdy();
		rd = hrdata;
	endtask

	task automatic model();
		int c;
		c = ctlM[2:0];
		oeE = dirM[4:0];
		outE = dataM[4:0];
		if (modeStrap inside {[3'h1:3'h5]}) begin
			for (int k = 1; k < 5; k++) begin
				if (dirM[k]) outE[k] = chipSelectN[4-k];
			end
			if (c != 0) begin
				oeE[2] = 1'b1;
				outE[2] = rowStrobeN[0];
			end
			if (c == 2 || c >= 4) begin
				oeE[1] = 1'b1;
				outE[1] = rowStrobeN[1];
			end else if (c != 0 && dirM[1]) outE[1] = dataM[1];
			if (ctlM[3]) begin
				oeE[0] = 1'b1;
				outE[0] = refreshStrobeN;
			end
		end
		lvl = (oeE & outE) | (~oeE & extVal);
	endtask

	task automatic checkAll();
		repeat (3) @(posedge clk_sys);
		model();
		`CHK("pinOe", oeE, pinOe)
		`CHK("pinOut", outE & oeE, pinOut & pinOe)
		`CHK("irq", enM[3:0] & ~lvl[3:0], irqRequest)
		`CHK("adc", lvl[3], adcTriggerN)
		ahb(1'b0, ADDR_DATA, 8'h0);
		`CHK("data", {27'h7, (dirM[4:0] & dataM[4:0]) | (~dirM[4:0] & lvl)}, rd)
		ahb(1'b0, ADDR_DIR, 8'h0);
		`CHK("dir", 32'hFF, rd)
	endtask

	task automatic resetModel(input int m);
		dirM = (m < 5) ? 8'hF0 : 8'hE0;
		dataM = 8'hE0;
		ctlM = 8'h0;
		enM = 8'h0;
	endtask

	// ----------------------------------------------------------------
	// Modes 1-7: reset state, random settings, hardware standby reload
	// ----------------------------------------------------------------
	initial begin
		for (int m = 1; m < 8; m++) begin
			@(posedge clk_sys);
			rst <= 1'b1;
			modeStrap <= m[2:0];
			repeat (4) @(posedge clk_sys);
			rst <= 1'b0;
			resetModel(m);
			checkAll();
			repeat (6) begin
				dirM = 8'($random(seed));
				dataM = 8'($random(seed));
				ctlM = 8'($random(seed)) & 8'h0F;
				enM = 8'($random(seed)) & 8'h0F;
				chipSelectN <= 4'($random(seed));
				rowStrobeN <= 2'($random(seed));
				refreshStrobeN <= 1'($random(seed));
				extVal <= 5'($random(seed));
				ahb(1'b1, ADDR_DIR, dirM);
				ahb(1'b1, ADDR_DATA, dataM);
				ahb(1'b1, ADDR_DRAM_CTL, ctlM);
				ahb(1'b1, ADDR_IRQ_EN, enM);
				ahb(1'b1, 32'h0000_0200, 8'hFF);
				ahb(1'b0, 32'h0000_0200, 8'h0);
				`CHK("unmapped", 32'h0, rd)
				checkAll();
			end
			hwStandby <= 1'b1;
			@(posedge clk_sys);
			hwStandby <= 1'b0;
			resetModel(m);
			checkAll();
		end
		finish_test();
	end
endmodule
